/* File: src/rrs_reset_strap.sv */
// Power-on reset release sequencer with test strap sampling and pin gating
`default_nettype none

// Overview of operation
// - Reset rising edge starts self-configuration.
// - Flash pins and GPIO tri-stated during reset.
// - LED selects and mirror enable low during reset.
// - No status output active while reset asserted.
// - Test pin tri-stated while reset low.
// - Sample test pin 1.5 us, then drive.
// - Unused bidirectional pins configurable as outputs.
module rrs_reset_strap #(
    parameter int unsigned SETTLE_CYCLES = rrs_pkg::SETTLE_CYCLES
) (
    // Clock and synchronous reset
    input wire logic mclk,
    input wire logic srst,
    // Asynchronous pins from the power controller
    input wire logic power_on_reset_n,
    input wire logic fast_park_n,
    // Core side drive requests
    input wire rrs_pkg::rrs_flash_t core_flash,
    input wire logic [rrs_pkg::GPIO_W-1:0] core_gpio_out,
    input wire logic [rrs_pkg::GPIO_W-1:0] core_gpio_dir,
    input wire logic core_test_out,
    input wire logic [rrs_pkg::LED_W-1:0] core_led_select,
    input wire logic core_mirror_enable_n,
    // Serial flash pins
    output logic [rrs_pkg::FLASH_W-1:0] flash_pins_oe_n,
    output rrs_pkg::rrs_flash_t flash_pins_out,
    // General purpose pins
    output logic [rrs_pkg::GPIO_W-1:0] gpio_out,
    output logic [rrs_pkg::GPIO_W-1:0] gpio_oe_n,
    // Test point 0, two-way pin
    input wire logic test_point_0_in,
    output logic test_point_0_out,
    output logic test_point_0_oe_n,
    // Always-driven outputs
    output logic [rrs_pkg::LED_W-1:0] led_select,
    output logic mirror_array_drive_enable_n,
    // Status to the rest of the chip
    output logic config_start,
    output logic test_mode_select,
    output logic host_bus_ready
);

    // Same time units as the bench; no delays are used here
    timeunit 1ns;
    timeprecision 100ps;

    // Registered state and its next value
    rrs_pkg::rrs_st_t st_ff;
    rrs_pkg::rrs_st_t nxt_st;

    // Last settle count, sized to the counter
    localparam logic [rrs_pkg::SETTLE_CNT_W-1:0] SETTLE_LAST =
        rrs_pkg::SETTLE_CNT_W'(SETTLE_CYCLES - 1);

    // Safe pin image used in reset and while the reset pin is low
    localparam rrs_pkg::rrs_st_t ST_RESET = '{
        state: rrs_pkg::st_held,
        sample_cnt: '0,
        settle_cnt: '0,
        flash_out: '0,
        flash_oe_n: rrs_pkg::FLASH_OE_N_RST,
        gpio_oe_n: rrs_pkg::GPIO_OE_N_RST,
        tp_oe_n: 1'b1,
        led_select: rrs_pkg::LED_RST,
        default: 1'b0
    };

    // Next-state logic for the whole sequencer
    always_comb
    begin
        nxt_st = st_ff;
        // Two-stage synchronisers; first stage feeds only the second
        nxt_st.por_meta = power_on_reset_n;
        nxt_st.por_sync = st_ff.por_meta;
        nxt_st.park_meta = fast_park_n;
        nxt_st.park_sync = st_ff.park_meta;
        nxt_st.tp_meta = test_point_0_in;
        nxt_st.tp_sync = st_ff.tp_meta;
        nxt_st.por_prev = st_ff.por_sync;
        nxt_st.config_start = 1'b0;

        if (!st_ff.por_sync)
        begin
            // Reset pin low: everything parked, strap forgotten
            nxt_st.state = rrs_pkg::st_held;
            nxt_st.sample_cnt = '0;
            nxt_st.test_mode_select = 1'b0;
            nxt_st.flash_out = '0;
            nxt_st.flash_oe_n = rrs_pkg::FLASH_OE_N_RST;
            nxt_st.gpio_out = '0;
            nxt_st.gpio_oe_n = rrs_pkg::GPIO_OE_N_RST;
            nxt_st.tp_out = 1'b0;
            nxt_st.tp_oe_n = 1'b1;
            nxt_st.led_select = rrs_pkg::LED_RST;
            nxt_st.mirror_array_drive_enable_n = 1'b0;
        end
        else
        begin
            unique case (st_ff.state)
                rrs_pkg::st_held:
                begin
                    // Only a real low-to-high edge starts configuration
                    if (!st_ff.por_prev)
                    begin
                        nxt_st.state = rrs_pkg::st_wait;
                        nxt_st.config_start = 1'b1;
                        nxt_st.sample_cnt = '0;
                    end
                end
                rrs_pkg::st_wait:
                begin
                    // Test pin stays released until its level is taken
                    nxt_st.sample_cnt = st_ff.sample_cnt + 1'b1;
                    if (st_ff.sample_cnt == rrs_pkg::SAMPLE_LAST)
                    begin
                        nxt_st.test_mode_select = st_ff.tp_sync;
                        nxt_st.state = rrs_pkg::st_run;
                    end
                end
                rrs_pkg::st_run:
                begin
                    // Strap is frozen; test pin becomes an output
                    nxt_st.test_mode_select = st_ff.test_mode_select;
                    nxt_st.tp_out = core_test_out;
                    nxt_st.tp_oe_n = 1'b0;
                end
            endcase

            // Flash and GPIO follow the core once out of reset; self-config
            // needs the flash during the strap wait, so no hold there
            if (st_ff.state != rrs_pkg::st_held)
            begin
                nxt_st.flash_out = core_flash;
                nxt_st.flash_oe_n = '0;
                nxt_st.gpio_out = core_gpio_out;
                nxt_st.gpio_oe_n = ~core_gpio_dir;
                nxt_st.led_select = core_led_select;
                nxt_st.mirror_array_drive_enable_n = core_mirror_enable_n;
            end
        end

        // Host bus hold-off; restarts if either pin drops
        if (st_ff.por_sync && st_ff.park_sync)
        begin
            if (st_ff.settle_cnt == SETTLE_LAST)
            begin
                nxt_st.host_bus_ready = 1'b1;
            end
            else
            begin
                nxt_st.settle_cnt = st_ff.settle_cnt + 1'b1;
            end
        end
        else
        begin
            nxt_st.settle_cnt = '0;
            nxt_st.host_bus_ready = 1'b0;
        end
    end

    // State register
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            st_ff <= ST_RESET;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // Outputs come straight from the state flip-flops
    assign flash_pins_out = st_ff.flash_out;
    assign flash_pins_oe_n = st_ff.flash_oe_n;
    assign gpio_out = st_ff.gpio_out;
    assign gpio_oe_n = st_ff.gpio_oe_n;
    assign test_point_0_out = st_ff.tp_out;
    assign test_point_0_oe_n = st_ff.tp_oe_n;
    assign led_select = st_ff.led_select;
    assign mirror_array_drive_enable_n = st_ff.mirror_array_drive_enable_n;
    assign config_start = st_ff.config_start;
    assign test_mode_select = st_ff.test_mode_select;
    assign host_bus_ready = st_ff.host_bus_ready;

    // Checking helper: cycles since the configuration start pulse
    logic [9:0] since_start_ff;
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            since_start_ff <= '0;
        end
        else if (st_ff.config_start)
        begin
            since_start_ff <= 10'h001;
        end
        else if (since_start_ff != 10'h3ff)
        begin
            since_start_ff <= since_start_ff + 10'h001;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    property p_cfg_start;
        $rose(st_ff.por_sync) |=> config_start ##1 !config_start;
    endproperty
    a_cfg_start: assert property (p_cfg_start)
        else $error("configuration start not a single pulse after reset release");

    property p_flash_gpio_float;
        !st_ff.por_sync |=> (flash_pins_oe_n == 4'hf) && (gpio_oe_n == 20'hfffff);
    endproperty
    a_flash_gpio_float: assert property (p_flash_gpio_float)
        else $error("flash or gpio driven while reset low");

    property p_led_mirror_low;
        !st_ff.por_sync |=> (led_select == 2'h0) && !mirror_array_drive_enable_n;
    endproperty
    a_led_mirror_low: assert property (p_led_mirror_low)
        else $error("led select or mirror enable not low in reset");

    property p_none_active;
        !st_ff.por_sync |=> !config_start && !host_bus_ready && !test_mode_select;
    endproperty
    a_none_active: assert property (p_none_active)
        else $error("status output active while reset low");

    property p_tp_float;
        !st_ff.por_sync [*2] |-> test_point_0_oe_n;
    endproperty
    a_tp_float: assert property (p_tp_float)
        else $error("test point driven while reset low");

    property p_tp_drive_time;
        $fell(test_point_0_oe_n) |-> since_start_ff == 10'(rrs_pkg::SAMPLE_CYCLES + 1);
    endproperty
    a_tp_drive_time: assert property (p_tp_drive_time)
        else $error("test point driven at the wrong time after release");

    property p_gpio_dir;
        (st_ff.state == rrs_pkg::st_run) && st_ff.por_sync
            |=> gpio_oe_n == ~$past(core_gpio_dir);
    endproperty
    a_gpio_dir: assert property (p_gpio_dir)
        else $error("gpio direction not taken from core after release");

    property p_strap_hold;
        (st_ff.state == rrs_pkg::st_run) && st_ff.por_sync |=> $stable(test_mode_select);
    endproperty
    a_strap_hold: assert property (p_strap_hold)
        else $error("strap value changed before next reset");

endmodule

`default_nettype wire

/* File: src/rrs_pkg.sv */
// Constants and types for the reset release and test strap block
`default_nettype none

package rrs_pkg;

    // Same time units as the bench, so mixed elaboration stays consistent
    timeunit 1ns;
    timeprecision 100ps;

    // Clock rate
    localparam int unsigned CLK_PERIOD_NS = 4;

    // Strap sampling delay after reset release, least time rounded up
    localparam int unsigned SAMPLE_TIME_NS = 1500;
    localparam int unsigned SAMPLE_CYCLES = (SAMPLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SAMPLE_CNT_W = 9;
    localparam logic [SAMPLE_CNT_W-1:0] SAMPLE_LAST = SAMPLE_CNT_W'(SAMPLE_CYCLES - 1);

    // Host bus hold-off after reset and park are both high
    localparam int unsigned SETTLE_TIME_MS = 500;
    localparam longint unsigned SETTLE_CYCLES_L = (longint'(SETTLE_TIME_MS) * 64'd1000000)
        / longint'(CLK_PERIOD_NS);
    localparam int unsigned SETTLE_CYCLES = int'(SETTLE_CYCLES_L);
    localparam int unsigned SETTLE_CNT_W = 27;

    // Pin group widths
    localparam int unsigned GPIO_W = 20;
    localparam int unsigned FLASH_W = 4;
    localparam int unsigned LED_W = 2;

    // Reset values of the pin drivers
    localparam logic [FLASH_W-1:0] FLASH_OE_N_RST = 4'hf;
    localparam logic [GPIO_W-1:0] GPIO_OE_N_RST = 20'hfffff;
    localparam logic [LED_W-1:0] LED_RST = 2'h0;

    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        st_held = 3'h1,
        st_wait = 3'h2,
        st_run  = 3'h4
    } rrs_state_t;

    // Serial flash pins travelling together
    typedef struct packed {
        logic flash_serial_clock;
        logic flash_serial_data_out;
        logic flash_chip_select_0_n;
        logic flash_chip_select_1_n;
    } rrs_flash_t;

    // Whole state of the sequencer
    typedef struct packed {
        rrs_state_t state;
        logic por_meta;
        logic por_sync;
        logic por_prev;
        logic park_meta;
        logic park_sync;
        logic tp_meta;
        logic tp_sync;
        logic [SAMPLE_CNT_W-1:0] sample_cnt;
        logic [SETTLE_CNT_W-1:0] settle_cnt;
        logic config_start;
        logic test_mode_select;
        logic host_bus_ready;
        rrs_flash_t flash_out;
        logic [FLASH_W-1:0] flash_oe_n;
        logic [GPIO_W-1:0] gpio_out;
        logic [GPIO_W-1:0] gpio_oe_n;
        logic tp_out;
        logic tp_oe_n;
        logic [LED_W-1:0] led_select;
        logic mirror_array_drive_enable_n;
    } rrs_st_t;

endpackage

`default_nettype wire

/* File: test/rrs_power_model.sv */
// Power controller and board strap model facing the reset block
`default_nettype none

module rrs_power_model (
    // Pacing clock
    input wire logic mclk,
    // Test point drive from the block
    input wire logic tp_out,
    input wire logic tp_oe_n,
    // Pins toward the block
    output logic por_n,
    output logic park_n,
    output logic tp_level
);
    timeunit 1ns;
    timeprecision 100ps;

    logic strap_up; // Board pull-up fitted on the test point

    // Pin level: block drive wins, else the pull-up or the weak pull-down
    assign tp_level = !tp_oe_n ? tp_out : strap_up;

    // Everything held low at power-up
    initial
    begin
        por_n = 1'b0;
        park_n = 1'b0;
        strap_up = 1'b0;
    end

    // Park first, then reset once the clocks have had time to settle
    task automatic power_up(input logic strap);
        @(posedge mclk);
        strap_up <= strap;
        park_n <= 1'b1;
        repeat (8) @(posedge mclk);
        por_n <= 1'b1;
    endtask

    // Both pins dropped together, as on a supply loss
    task automatic power_down();
        @(posedge mclk);
        por_n <= 1'b0;
        park_n <= 1'b0;
    endtask

    // Park pin alone, reset stays released
    task automatic set_park(input logic v);
        @(posedge mclk);
        park_n <= v;
    endtask
endmodule

`default_nettype wire

/* File: test/testbench.sv */
// Self-checking bench for the reset release and strap block
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    logic mclk = 1'b0; // 250 MHz clock
    logic srst = 1'b1; // Held for the first cycles
    // Core requests, distinct from the safe image on purpose
    rrs_pkg::rrs_flash_t core_flash = 4'h5;
    logic [19:0] core_gpio_out = 20'hab5c3;
    logic [19:0] core_gpio_dir = 20'h0f0f1;
    logic core_test_out = 1'b0;
    logic [1:0] core_led = 2'h3;
    logic core_mirror_n = 1'b1;
    // Block outputs
    logic [3:0] flash_oe_n;
    rrs_pkg::rrs_flash_t flash_out;
    logic [19:0] gpio_out, gpio_oe_n;
    logic tp_out, tp_oe_n, tp_level, por_n, park_n;
    logic [1:0] led;
    logic mirror_n, cfg, tms, rdy;
    int failures = 0;
    int num_checks = 0;

    // Half period of 2 ns
    always #2 mclk = ~mclk;

    rrs_reset_strap #(.SETTLE_CYCLES(20)) uut (
        .mclk(mclk), .srst(srst), .power_on_reset_n(por_n), .fast_park_n(park_n),
        .core_flash(core_flash), .core_gpio_out(core_gpio_out), .core_gpio_dir(core_gpio_dir),
        .core_test_out(core_test_out), .core_led_select(core_led),
        .core_mirror_enable_n(core_mirror_n), .flash_pins_oe_n(flash_oe_n),
        .flash_pins_out(flash_out), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
        .test_point_0_in(tp_level), .test_point_0_out(tp_out), .test_point_0_oe_n(tp_oe_n),
        .led_select(led), .mirror_array_drive_enable_n(mirror_n), .config_start(cfg),
        .test_mode_select(tms), .host_bus_ready(rdy)
    );

    rrs_power_model pm (
        .mclk(mclk), .tp_out(tp_out), .tp_oe_n(tp_oe_n),
        .por_n(por_n), .park_n(park_n), .tp_level(tp_level)
    );

    // One edge, then let its updates land before looking
    task automatic step();
        @(posedge mclk);
        #1;
    endtask

    // Shared comparison, counts every call
    task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Verdict and end of run
    task automatic end_of_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
        begin
            $display("bench passed");
        end
        else
        begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Safe image while the reset pin is low
    task automatic check_safe();
        check("flash_oe_n", 20'(flash_oe_n), 20'hf);
        check("gpio_oe_n", gpio_oe_n, 20'hfffff);
        check("tp_oe_n", 20'(tp_oe_n), 20'h1);
        check("led_mirror", 20'({led, mirror_n}), 20'h0);
        check("status", 20'({cfg, tms, rdy}), 20'h0);
    endtask

    // Release, start pulse, strap sampling and pin hand-over
    task automatic sc_boot(input logic strap);
        int n;
        int rdy_at;
        n = 0;
        rdy_at = 0;
        pm.power_up(strap);
        while (tp_oe_n !== 1'b0 && n < 500)
        begin
            step();
            n++;
            check("config_start", 20'(cfg), 20'(n == 3));
            check("strap_early", 20'(tms), 20'(strap && n >= 378));
            if (rdy === 1'b1 && rdy_at == 0)
            begin
                rdy_at = n;
            end
        end
        // A hang is a mismatch
        if (n >= 500)
        begin
            failures++;
            end_of_test();
        end
        check("strap_delay", 20'(n), 20'd379);
        check("ready_delay", 20'(rdy_at inside {[22:24]}), 20'h1);
        check("flash_out", 20'({flash_out, flash_oe_n}), 20'h50);
        check("gpio_out", gpio_out, 20'hab5c3);
        check("gpio_oe_n", gpio_oe_n, ~20'h0f0f1);
        check("led_mirror", 20'({led, mirror_n}), 20'h7);
        check("strap", 20'(tms), 20'(strap));
        // Drive the opposite level back through the pin
        @(posedge mclk);
        core_test_out <= ~strap;
        repeat (5) step();
        check("tp_drive", 20'(tp_level), 20'(!strap));
        check("strap_held", 20'(tms), 20'(strap));
    endtask

    // Park pulse closes the host gate and restarts the hold-off
    task automatic sc_park();
        int n;
        n = 0;
        pm.set_park(1'b0);
        repeat (4) step();
        check("ready_drop", 20'(rdy), 20'h0);
        pm.set_park(1'b1);
        while (rdy !== 1'b1 && n < 100)
        begin
            step();
            n++;
        end
        check("ready_again", 20'(n inside {[22:24]}), 20'h1);
        // A hang was counted above; go straight to the report
        if (n >= 100)
        begin
            end_of_test();
        end
    endtask

    // Reset pin dropped in mid-run, image must return and hold
    task automatic sc_down();
        pm.power_down();
        repeat (3) step();
        check_safe();
        repeat (40) step();
        check_safe();
    endtask

    // Main sequence
    initial
    begin
        repeat (3) @(posedge mclk);
        srst <= 1'b0;
        repeat (4) step();
        check_safe();
        sc_boot(1'b0);
        sc_park();
        sc_down();
        sc_boot(1'b1);
        sc_down();
        end_of_test();
    end
endmodule

`default_nettype wire
